// *** core/mecr_pkg.sv ***
// package: offsets, field positions, reset values and timing constants of the config bank
package mecr_pkg;
    // =====================================================
    // register offsets
    localparam logic [7:0] MECR_ADDR_FUNC_CFG   = 8'h58;
    localparam logic [7:0] MECR_ADDR_ORIENT_THS = 8'h59;
    localparam logic [7:0] MECR_ADDR_TAP_TIMING = 8'h5a;
    localparam logic [7:0] MECR_ADDR_ACT_THS    = 8'h5b;
    localparam logic [7:0] MECR_ADDR_ACT_DUR    = 8'h5c;
    localparam logic [7:0] MECR_ADDR_DROP_CFG   = 8'h5d;
    localparam logic [7:0] MECR_RESET_VALUE     = 8'h00;
    localparam int         MECR_NUM_REGS        = 6;

    // =====================================================
    // field positions
    localparam int MECR_BIT_TS_EN      = 7;
    localparam int MECR_BIT_STEP_EN    = 6;
    localparam int MECR_BIT_TILT_EN    = 5;
    localparam int MECR_BIT_FILT_SEL   = 4;
    localparam int MECR_BIT_TAP_X      = 3;
    localparam int MECR_BIT_TAP_Y      = 2;
    localparam int MECR_BIT_TAP_Z      = 1;
    localparam int MECR_BIT_LATCH      = 0;
    localparam int MECR_BIT_FOUR_DIR   = 7;
    localparam int MECR_POS_ORIENT_THS = 5;
    localparam int MECR_POS_KNOCK_THS  = 0;
    localparam int MECR_POS_GAP        = 4;
    localparam int MECR_POS_QUIET      = 2;
    localparam int MECR_POS_SHOCK      = 0;
    localparam int MECR_BIT_DOUBLE     = 7;
    localparam int MECR_BIT_INACT      = 6;
    localparam int MECR_POS_ACT_THS    = 0;
    localparam int MECR_BIT_DROP_MSB   = 7;
    localparam int MECR_POS_ACT_DUR    = 5;
    localparam int MECR_BIT_TS_RES     = 4;
    localparam int MECR_POS_SLEEP      = 0;
    localparam int MECR_POS_DROP_LOW   = 3;
    localparam int MECR_POS_DROP_THS   = 0;

    // =====================================================
    // timing in accel sample periods
    localparam logic [9:0]  MECR_GAP_ZERO_PER    = 10'h010;
    localparam logic [9:0]  MECR_GAP_STEP_PER    = 10'h020;
    localparam logic [9:0]  MECR_QUIET_ZERO_PER  = 10'h002;
    localparam logic [9:0]  MECR_QUIET_STEP_PER  = 10'h004;
    localparam logic [9:0]  MECR_SHOCK_ZERO_PER  = 10'h004;
    localparam logic [9:0]  MECR_SHOCK_STEP_PER  = 10'h008;
    localparam logic [13:0] MECR_SLEEP_STEP_PER  = 14'h0200;

    // timestamp tick in ns and in clk cycles at 100 ns
    localparam longint MECR_CLK_PERIOD_NS  = 100;
    localparam longint MECR_TICK_SLOW_NS   = 6400000;
    localparam longint MECR_TICK_FAST_NS   = 25000;
    localparam int     MECR_TICK_SLOW_CYC  = int'(MECR_TICK_SLOW_NS / MECR_CLK_PERIOD_NS);
    localparam int     MECR_TICK_FAST_CYC  = int'(MECR_TICK_FAST_NS / MECR_CLK_PERIOD_NS);

    // free-fall threshold in mg, per code
    typedef logic [8:0] mecr_mg_type;
    function automatic mecr_mg_type mecr_drop_mg(input logic [2:0] code);
        case (code)
            3'h0:    mecr_drop_mg = 9'd156;
            3'h1:    mecr_drop_mg = 9'd219;
            3'h2:    mecr_drop_mg = 9'd250;
            3'h3:    mecr_drop_mg = 9'd312;
            3'h4:    mecr_drop_mg = 9'd344;
            3'h5:    mecr_drop_mg = 9'd406;
            3'h6:    mecr_drop_mg = 9'd469;
            default: mecr_drop_mg = 9'd500;
        endcase
    endfunction : mecr_drop_mg

    // orientation threshold in degrees, per code
    function automatic logic [6:0] mecr_orient_deg(input logic [1:0] code);
        case (code)
            2'h0:    mecr_orient_deg = 7'd80;
            2'h1:    mecr_orient_deg = 7'd70;
            2'h2:    mecr_orient_deg = 7'd60;
            default: mecr_orient_deg = 7'd50;
        endcase
    endfunction : mecr_orient_deg

    // code zero has its own length, other codes scale per step
    function automatic logic [9:0] mecr_periods(input logic [3:0] code,
                                                input logic [9:0] zero_per,
                                                input logic [9:0] step_per);
        logic [13:0] prod;
        prod = 14'(code) * 14'(step_per);
        mecr_periods = (code == 4'h0) ? zero_per : prod[9:0];
    endfunction : mecr_periods
endpackage : mecr_pkg

// *** core/mecr_sync_reset.sv ***
// reset release synchroniser
`timescale 1ns/1ps
module mecr_sync_reset (
    // clock and raw reset
    input  wire logic clk,
    input  wire logic rst_b,
    // released reset
    output logic      rst_sync_b
);
    logic stage1_reg;
    logic stage2_reg;

    // =====================================================
    // assert at once, release after two edges
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= 1'b1;
            stage2_reg <= stage1_reg;
        end
    end
    assign rst_sync_b = stage2_reg;
endmodule : mecr_sync_reset

// *** core/mecr_timestamp.sv ***
// free-running timestamp counter with selectable tick
`timescale 1ns/1ps
module mecr_timestamp
    import mecr_pkg::*;
#(
    parameter int SLOW_CYC = MECR_TICK_SLOW_CYC,
    parameter int FAST_CYC = MECR_TICK_FAST_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_sync_b,
    // control
    input  wire logic        enable,
    input  wire logic        fine_res,
    // count
    output logic      [23:0] count
);
    import mecr_pkg::*;

    initial begin
        if (SLOW_CYC < 1 || FAST_CYC < 1 || SLOW_CYC > 16777215 || FAST_CYC > 16777215)
            $error("tick counts out of range");
    end

    logic [23:0] div_reg;
    logic [23:0] div_next;
    logic [23:0] count_reg;
    logic [23:0] count_next;
    logic [23:0] limit;

    // =====================================================
    // divider restarts when off so first tick is a full period
    always_comb begin
        limit      = fine_res ? 24'(FAST_CYC - 1) : 24'(SLOW_CYC - 1);
        div_next   = div_reg;
        count_next = count_reg;
        if (!enable) begin
            div_next = 24'h00_0000;
        end else if (div_reg >= limit) begin
            div_next   = 24'h00_0000;
            count_next = count_reg + 24'h00_0001;
        end else begin
            div_next = div_reg + 24'h00_0001;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            div_reg   <= 24'h00_0000;
            count_reg <= 24'h00_0000;
        end else begin
            div_reg   <= div_next;
            count_reg <= count_next;
        end
    end
    assign count = count_reg;

    // =====================================================
    // checks
    a_count_frozen_off : assert property (@(posedge clk) disable iff (!rst_sync_b)
        !enable |=> $stable(count_reg)) else $error("timestamp moved while off");
    a_div_bound : assert property (@(posedge clk) disable iff (!rst_sync_b)
        div_reg <= 24'(SLOW_CYC - 1)) else $error("divider overran");
endmodule : mecr_timestamp

// *** core/mecr_regs.sv ***
// motion event configuration register bank, top
`timescale 1ns/1ps
module mecr_regs
    import mecr_pkg::*;
#(
    parameter int SLOW_CYC = MECR_TICK_SLOW_CYC,
    parameter int FAST_CYC = MECR_TICK_FAST_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // register port from the serial host interface
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_hit,
    // engine enables
    output logic             timestamp_enable,
    output logic             step_algorithm_enable,
    output logic             tilt_enable,
    output logic             filter_path_select,
    output logic      [2:0]  tap_axis_enable,
    output logic             interrupt_latch_select,
    output logic             six_direction_orientation,
    output logic             four_direction_mode,
    output logic             double_knock_enable,
    output logic             inactivity_enable,
    // thresholds
    output logic      [1:0]  orientation_threshold,
    output logic      [6:0]  orientation_degrees,
    output logic      [4:0]  knock_threshold,
    output logic      [5:0]  activity_threshold_field,
    output logic      [2:0]  drop_threshold,
    output logic      [8:0]  drop_threshold_mg,
    // durations in accel sample periods
    output logic      [9:0]  double_knock_gap,
    output logic      [9:0]  knock_quiet_periods,
    output logic      [9:0]  knock_shock_periods,
    output logic      [1:0]  activity_duration_field,
    output logic      [13:0] sleep_entry_delay,
    output logic      [5:0]  drop_duration,
    // timestamp
    output logic             timestamp_resolution_select,
    output logic      [23:0] timestamp_count
);
    import mecr_pkg::*;

    logic rst_sync_b;

    // =====================================================
    // reset release
    mecr_sync_reset u_rst (
        .clk        (clk),
        .rst_b      (rst_b),
        .rst_sync_b (rst_sync_b)
    );

    // =====================================================
    // register storage, indexed from the first offset
    logic [7:0] bank_reg  [MECR_NUM_REGS];
    logic [7:0] bank_next [MECR_NUM_REGS];
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       hit_reg;
    logic       hit_next;
    logic       addr_ok;
    logic [2:0] idx;

    function automatic logic in_bank(input logic [7:0] a);
        in_bank = (a >= MECR_ADDR_FUNC_CFG) && (a <= MECR_ADDR_DROP_CFG);
    endfunction : in_bank

    always_comb begin
        logic [7:0] off;
        off     = reg_addr - MECR_ADDR_FUNC_CFG;
        idx     = off[2:0];
        addr_ok = in_bank(reg_addr);
        for (int i = 0; i < MECR_NUM_REGS; i++) begin
            bank_next[i] = bank_reg[i];
        end
        if (reg_wr && addr_ok) begin
            bank_next[idx] = reg_wdata;
        end
        // unmapped reads return zero with hit low
        rdata_next = rdata_reg;
        hit_next   = 1'b0;
        if (reg_rd) begin
            rdata_next = addr_ok ? bank_reg[idx] : 8'h00;
            hit_next   = addr_ok;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            for (int i = 0; i < MECR_NUM_REGS; i++) begin
                bank_reg[i] <= MECR_RESET_VALUE;
            end
            rdata_reg <= 8'h00;
            hit_reg   <= 1'b0;
        end else begin
            for (int i = 0; i < MECR_NUM_REGS; i++) begin
                bank_reg[i] <= bank_next[i];
            end
            rdata_reg <= rdata_next;
            hit_reg   <= hit_next;
        end
    end
    assign reg_rdata = rdata_reg;
    assign reg_hit   = hit_reg;

    // =====================================================
    // field decode
    logic [7:0] cfg;
    logic [7:0] ths6;
    logic [7:0] tim;
    logic [7:0] wth;
    logic [7:0] wdur;
    logic [7:0] ffr;
    assign cfg  = bank_reg[0];
    assign ths6 = bank_reg[1];
    assign tim  = bank_reg[2];
    assign wth  = bank_reg[3];
    assign wdur = bank_reg[4];
    assign ffr  = bank_reg[5];

    assign timestamp_enable       = cfg[MECR_BIT_TS_EN];
    assign step_algorithm_enable  = cfg[MECR_BIT_STEP_EN];
    assign tilt_enable            = cfg[MECR_BIT_TILT_EN];
    assign filter_path_select     = cfg[MECR_BIT_FILT_SEL];
    assign tap_axis_enable        = {cfg[MECR_BIT_TAP_X], cfg[MECR_BIT_TAP_Y],
                                     cfg[MECR_BIT_TAP_Z]};
    assign interrupt_latch_select = cfg[MECR_BIT_LATCH];

    // zero in the bit means four-direction mode on
    assign four_direction_mode       = ~ths6[MECR_BIT_FOUR_DIR];
    assign six_direction_orientation = ths6[MECR_BIT_FOUR_DIR];
    assign orientation_threshold     = ths6[MECR_POS_ORIENT_THS +: 2];
    assign orientation_degrees       = mecr_orient_deg(orientation_threshold);
    assign knock_threshold           = ths6[MECR_POS_KNOCK_THS +: 5];

    assign double_knock_gap    = mecr_periods(tim[MECR_POS_GAP +: 4],
                                              MECR_GAP_ZERO_PER, MECR_GAP_STEP_PER);
    assign knock_quiet_periods = mecr_periods({2'b00, tim[MECR_POS_QUIET +: 2]},
                                              MECR_QUIET_ZERO_PER, MECR_QUIET_STEP_PER);
    assign knock_shock_periods = mecr_periods({2'b00, tim[MECR_POS_SHOCK +: 2]},
                                              MECR_SHOCK_ZERO_PER, MECR_SHOCK_STEP_PER);

    assign double_knock_enable      = wth[MECR_BIT_DOUBLE];
    assign inactivity_enable        = wth[MECR_BIT_INACT];
    assign activity_threshold_field = wth[MECR_POS_ACT_THS +: 6];

    assign activity_duration_field     = wdur[MECR_POS_ACT_DUR +: 2];
    assign timestamp_resolution_select = wdur[MECR_BIT_TS_RES];
    // limitation: longest delay 15*512 periods fits 14 bits
    assign sleep_entry_delay = 14'(wdur[MECR_POS_SLEEP +: 4]) * MECR_SLEEP_STEP_PER;
    assign drop_duration     = {wdur[MECR_BIT_DROP_MSB], ffr[MECR_POS_DROP_LOW +: 5]};
    assign drop_threshold    = ffr[MECR_POS_DROP_THS +: 3];
    assign drop_threshold_mg = mecr_drop_mg(drop_threshold);

    // =====================================================
    // timestamp engine
    mecr_timestamp #(
        .SLOW_CYC (SLOW_CYC),
        .FAST_CYC (FAST_CYC)
    ) u_ts (
        .clk        (clk),
        .rst_sync_b (rst_sync_b),
        .enable     (timestamp_enable),
        .fine_res   (timestamp_resolution_select),
        .count      (timestamp_count)
    );

    // =====================================================
    // checks
    a_write_readback : assert property (@(posedge clk) disable iff (!rst_sync_b)
        (reg_wr && addr_ok && !reg_rd) ##1 !reg_wr
        ##1 (reg_rd && !reg_wr && $past(reg_addr, 2) == reg_addr)
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("readback mismatch");
    a_unmapped_zero : assert property (@(posedge clk) disable iff (!rst_sync_b)
        (reg_rd && !addr_ok) |=> (reg_rdata == 8'h00 && !reg_hit))
        else $error("unmapped read not zero");
    a_gap_decode : assert property (@(posedge clk) disable iff (!rst_sync_b)
        (tim[MECR_POS_GAP +: 4] == 4'h0) |-> double_knock_gap == MECR_GAP_ZERO_PER)
        else $error("gap code zero wrong");
    a_quiet_decode : assert property (@(posedge clk) disable iff (!rst_sync_b)
        (tim[MECR_POS_QUIET +: 2] != 2'h0) |->
        knock_quiet_periods == 10'(tim[MECR_POS_QUIET +: 2]) * MECR_QUIET_STEP_PER)
        else $error("quiet decode wrong");
    a_shock_decode : assert property (@(posedge clk) disable iff (!rst_sync_b)
        (tim[MECR_POS_SHOCK +: 2] == 2'h0) |-> knock_shock_periods == MECR_SHOCK_ZERO_PER)
        else $error("shock decode wrong");
    a_orient_decode : assert property (@(posedge clk) disable iff (!rst_sync_b)
        orientation_degrees == 7'(7'd80 - 7'd10 * 7'(orientation_threshold)))
        else $error("orientation decode wrong");
    a_drop_span : assert property (@(posedge clk) disable iff (!rst_sync_b)
        (reg_wr && reg_addr == MECR_ADDR_ACT_DUR) |=>
        drop_duration[5] == $past(reg_wdata[MECR_BIT_DROP_MSB]))
        else $error("drop msb not taken");
    a_sleep_scale : assert property (@(posedge clk) disable iff (!rst_sync_b)
        sleep_entry_delay[8:0] == 9'h000) else $error("sleep delay not 512 multiple");
    a_reset_off : assert property (@(posedge clk)
        $rose(rst_sync_b) |-> (!timestamp_enable && !step_algorithm_enable && !tilt_enable
        && !inactivity_enable && four_direction_mode))
        else $error("enables not off after reset");

    c_enable_ts : cover property (@(posedge clk) disable iff (!rst_sync_b)
        $rose(timestamp_enable));
    c_fine_tick : cover property (@(posedge clk) disable iff (!rst_sync_b)
        timestamp_resolution_select && $changed(timestamp_count));
    c_double_tap : cover property (@(posedge clk) disable iff (!rst_sync_b)
        double_knock_enable && double_knock_gap != MECR_GAP_ZERO_PER);
    c_max_drop : cover property (@(posedge clk) disable iff (!rst_sync_b)
        drop_duration == 6'h3f);
endmodule : mecr_regs

// *** tb/mecr_host_model.sv ***
// host-side model of the serial register port feeding the config bank
`timescale 1ns/1ps
module mecr_host_model (
    // clock
    input  wire logic       clk,
    // register port requests
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    // register port answers
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_hit
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // =====================================================
    // bus cycles, launched and released on the falling edge
    // idle lines carry the inverse of the last value so a stale sample shows
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_addr  = ~addr;
        reg_wdata = ~data;
    endtask : wr

    // answer is registered on the strobe edge, taken at the next falling edge
    task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic hit);
        @(negedge clk);
        reg_addr = addr;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        reg_addr = ~addr;
        data     = reg_rdata;
        hit      = reg_hit;
    endtask : rd
endmodule : mecr_host_model

// *** tb/test_mecr_regs.sv ***
// self-checking bench for the motion event config bank
`timescale 1ns/1ps
module test_mecr_regs;
    import mecr_pkg::*;
    // short ticks keep the timestamp runs brief
    localparam int SLOW = 8;
    localparam int FAST = 2;
    logic        clk, rst_b, reg_wr, reg_rd, reg_hit;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic        timestamp_enable, step_algorithm_enable, tilt_enable, filter_path_select;
    logic [2:0]  tap_axis_enable, drop_threshold;
    logic        interrupt_latch_select, six_direction_orientation, four_direction_mode;
    logic        double_knock_enable, inactivity_enable, timestamp_resolution_select;
    logic [1:0]  orientation_threshold, activity_duration_field;
    logic [6:0]  orientation_degrees;
    logic [4:0]  knock_threshold;
    logic [5:0]  activity_threshold_field, drop_duration;
    logic [8:0]  drop_threshold_mg;
    logic [9:0]  double_knock_gap, knock_quiet_periods, knock_shock_periods;
    logic [13:0] sleep_entry_delay;
    logic [23:0] timestamp_count;
    int          bad_count, n_tests;
    int          deg_tab [4] = '{80, 70, 60, 50};
    int          mg_tab  [8] = '{156, 219, 250, 312, 344, 406, 469, 500};

    mecr_regs #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) i_mecr_regs (
        .clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit,
        .timestamp_enable, .step_algorithm_enable, .tilt_enable, .filter_path_select,
        .tap_axis_enable, .interrupt_latch_select, .six_direction_orientation,
        .four_direction_mode, .double_knock_enable, .inactivity_enable,
        .orientation_threshold, .orientation_degrees, .knock_threshold,
        .activity_threshold_field, .drop_threshold, .drop_threshold_mg,
        .double_knock_gap, .knock_quiet_periods, .knock_shock_periods,
        .activity_duration_field, .sleep_entry_delay, .drop_duration,
        .timestamp_resolution_select, .timestamp_count);

    mecr_host_model i_mecr_host_model (
        .clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit);

    initial clk = 1'b0;
    always #50 clk = ~clk;

    // =====================================================
    // checking helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp, input logic hit);
        logic [7:0] d;
        logic       h;
        i_mecr_host_model.rd(addr, d, h);
        chk(d, exp);
        chk(h, hit);
    endtask : rdchk

    task automatic finish_test;
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    // =====================================================
    // scenarios
    task automatic t_reset;
        for (int a = 0; a < MECR_NUM_REGS; a++) begin
            rdchk(MECR_ADDR_FUNC_CFG + 8'(a), 8'h00, 1'b1);
        end
        chk({timestamp_enable, step_algorithm_enable, tilt_enable}, 0);
        chk({filter_path_select, tap_axis_enable, interrupt_latch_select}, 0);
        chk(four_direction_mode, 1);
        chk(orientation_degrees, 80);
        chk(knock_threshold, 0);
        chk({double_knock_gap, knock_quiet_periods, knock_shock_periods}, {10'd16, 10'd2, 10'd4});
        chk({double_knock_enable, inactivity_enable, activity_threshold_field}, 0);
        chk({activity_duration_field, timestamp_resolution_select, sleep_entry_delay}, 0);
        chk({drop_duration, drop_threshold_mg}, 156);
    endtask : t_reset

    task automatic t_func_bits;
        for (int i = 0; i < 8; i++) begin
            i_mecr_host_model.wr(MECR_ADDR_FUNC_CFG, 8'h01 << i);
            chk({timestamp_enable, step_algorithm_enable, tilt_enable, filter_path_select,
                 tap_axis_enable, interrupt_latch_select}, 32'h0000_0001 << i);
            rdchk(MECR_ADDR_FUNC_CFG, 8'h01 << i, 1'b1);
        end
        i_mecr_host_model.wr(MECR_ADDR_FUNC_CFG, 8'h00);
    endtask : t_func_bits

    task automatic t_orient;
        logic [7:0] v;
        for (int c = 0; c < 4; c++) begin
            v = {c[0], c[1:0], 5'(c * 11)};
            i_mecr_host_model.wr(MECR_ADDR_ORIENT_THS, v);
            chk({four_direction_mode, six_direction_orientation}, {~c[0], c[0]});
            chk({orientation_threshold, orientation_degrees}, {c[1:0], 7'(deg_tab[c])});
            chk(knock_threshold, v[4:0]);
            rdchk(MECR_ADDR_ORIENT_THS, v, 1'b1);
        end
    endtask : t_orient

    task automatic t_tap_timing;
        logic [1:0] q;
        for (int g = 0; g < 16; g++) begin
            q = 2'(g);
            i_mecr_host_model.wr(MECR_ADDR_TAP_TIMING, {4'(g), q, ~q});
            chk(double_knock_gap, (g == 0) ? 16 : g * 32);
            chk(knock_quiet_periods, (q == 0) ? 2 : q * 4);
            chk(knock_shock_periods, (q == 3) ? 4 : (3 - q) * 8);
        end
    endtask : t_tap_timing

    task automatic t_activity;
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            v = 8'(i * 8'h55);
            i_mecr_host_model.wr(MECR_ADDR_ACT_THS, v);
            chk(double_knock_enable, v[7]);
            chk(inactivity_enable, v[6]);
            chk(activity_threshold_field, v[5:0]);
            rdchk(MECR_ADDR_ACT_THS, v, 1'b1);
        end
    endtask : t_activity

    task automatic t_dur_drop;
        logic [7:0] a;
        logic [7:0] b;
        for (int i = 0; i < 16; i++) begin
            a = 8'(i * 8'h11);
            b = {5'(i * 3), 3'(i)};
            i_mecr_host_model.wr(MECR_ADDR_ACT_DUR, a);
            i_mecr_host_model.wr(MECR_ADDR_DROP_CFG, b);
            chk(activity_duration_field, a[6:5]);
            chk(timestamp_resolution_select, a[4]);
            chk(sleep_entry_delay, a[3:0] * 512);
            chk(drop_duration, {a[7], b[7:3]});
            chk({drop_threshold, drop_threshold_mg}, {b[2:0], 9'(mg_tab[i % 8])});
            rdchk(MECR_ADDR_DROP_CFG, b, 1'b1);
        end
    endtask : t_dur_drop

    task automatic t_unmapped;
        i_mecr_host_model.wr(MECR_ADDR_FUNC_CFG - 8'h01, 8'hff);
        i_mecr_host_model.wr(MECR_ADDR_DROP_CFG + 8'h01, 8'hff);
        rdchk(MECR_ADDR_FUNC_CFG - 8'h01, 8'h00, 1'b0);
        rdchk(MECR_ADDR_DROP_CFG + 8'h01, 8'h00, 1'b0);
        rdchk(MECR_ADDR_FUNC_CFG, 8'h00, 1'b1);
    endtask : t_unmapped

    // resolution is set before the enable goes high
    task automatic t_stamp(input logic fine, input int per, input int lo, input int hi);
        logic [23:0] c0;
        logic [23:0] d;
        i_mecr_host_model.wr(MECR_ADDR_ACT_DUR, {3'h0, fine, 4'h0});
        c0 = timestamp_count;
        i_mecr_host_model.wr(MECR_ADDR_FUNC_CFG, 8'h80);
        repeat (per * 5) @(posedge clk);
        i_mecr_host_model.wr(MECR_ADDR_FUNC_CFG, 8'h00);
        d = timestamp_count - c0;
        chk(d >= 24'(lo) && d <= 24'(hi), 1);
        c0 = timestamp_count;
        repeat (30) @(posedge clk);
        chk(timestamp_count, c0);
    endtask : t_stamp

    // reset in mid-run clears the orientation register written just before it
    task automatic t_midreset;
        i_mecr_host_model.wr(MECR_ADDR_ORIENT_THS, 8'hff);
        @(negedge clk);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(posedge clk);
        rdchk(MECR_ADDR_ORIENT_THS, 8'h00, 1'b1);
        chk(four_direction_mode, 1);
    endtask : t_midreset

    // =====================================================
    // main sequence
    initial begin
        rst_b     = 1'b0;
        bad_count = 0;
        n_tests   = 0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_func_bits;
        t_orient;
        t_tap_timing;
        t_activity;
        t_dur_drop;
        t_unmapped;
        t_stamp(1'b0, SLOW, 4, 6);
        t_stamp(1'b1, FAST, 4, 7);
        t_midreset;
        finish_test;
    end

    // watchdog, well beyond the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test;
    end
endmodule : test_mecr_regs
